// File: rtl/atc_tx_assembly.sv
`timescale 1ns/1ps
module atc_tx_assembly (
  input  wire logic               sys_clk,
  input  wire logic               rst_n,
  input  wire atc_pkg::atc_chan_s chan,
  input  wire atc_pkg::atc_svc_s  svc,
  input  wire atc_pkg::atc_inj_s  inj,
  output logic                    busy,
  output logic                    bad_buf_size,
  output atc_pkg::atc_pkt_s       pkt_out,
  output atc_pkg::atc_wb_s        wb_out
);

  typedef struct packed {
    atc_pkg::atc_fsm_e fsm;
    logic              busy;
    logic              bad_buf;
    logic              div_go;
    atc_pkg::atc_chan_s ch;
    atc_pkg::atc_svc_s  ev;
    logic [31:0]       rem_adj;
    logic              wrapped;
    atc_pkg::atc_pkt_s pkt;
    atc_pkg::atc_wb_s  wb;
  } atc_top_s;

  atc_top_s st_reg;
  atc_top_s st_next;

  logic [15:0] ring_add;
  logic [9:0]  ring_sum;
  logic        ring_bad;
  logic [32:0] div_dividend;
  logic        div_done;
  logic [32:0] div_q;
  logic [15:0] total_samples;
  logic [15:0] payload_len;
  logic [4:0]  seq_uui;

  function automatic logic [4:0] seq_mask(input logic [2:0] nbits);
    logic [2:0] n;
    n = (nbits > atc_pkg::SEQ_BITS_MAX) ? atc_pkg::SEQ_BITS_MAX : nbits;
    seq_mask = (atc_pkg::UUI_ONE << n) - atc_pkg::UUI_ONE;
  endfunction

  // Per-type fixed bits above the sequence field
  function automatic logic [4:0] merge_uui(
    input logic [4:0] fixed,
    input logic [4:0] seq,
    input logic [2:0] nbits
  );
    logic [4:0] m;
    m = seq_mask(nbits);
    merge_uui = (fixed & ~m) | (seq & m);
  endfunction

  function automatic logic [15:0] payload_octets(
    input atc_pkg::atc_rate_e rate,
    input logic [15:0] samples,
    input logic [15:0] sid_len
  );
    logic [18:0] bits;
    bits = 19'h00000;
    unique case (rate)
      atc_pkg::ATC_RATE_64:  bits = {samples, 3'h0};
      atc_pkg::ATC_RATE_40:  bits = {3'h0, samples} * 19'h00005;
      atc_pkg::ATC_RATE_32:  bits = {1'b0, samples, 2'h0};
      atc_pkg::ATC_RATE_24:  bits = {3'h0, samples} * 19'h00003;
      atc_pkg::ATC_RATE_16:  bits = {2'h0, samples, 1'b0};
      atc_pkg::ATC_RATE_SID: bits = {sid_len, 3'h0};
      default:               bits = {samples, 3'h0};
    endcase
    payload_octets = bits[18:3];
  endfunction

  function automatic atc_pkg::atc_wb_s wb_from(input atc_pkg::atc_chan_s c);
    atc_pkg::atc_wb_s w;
    w.valid    = 1'b1;
    w.init     = c.init;
    w.next_ptr = c.next_ptr;
    w.t_rem    = c.t_rem;
    w.t_msb    = c.t_msb;
    w.pkt_cnt  = c.pkt_cnt;
    w.oct_cnt  = c.oct_cnt;
    wb_from = w;
  endfunction

  function automatic logic [31:0] count_octets(
    input logic [31:0] cnt,
    input logic [15:0] li
  );
    count_octets = cnt + {16'h0000, li} + atc_pkg::OCTET_OVERHEAD;
  endfunction

  // One ring adder serves both the first-service alignment and the advance
  assign ring_add = (st_reg.fsm == atc_pkg::ATC_S_SEQ) ? {8'h00, st_reg.ch.spp}
                                                       : {6'h00, st_reg.ev.wr_ptr};

  atc_ring_ptr u_ring (
    .base     (st_reg.ch.next_ptr),
    .add      (ring_add),
    .buf_size (st_reg.ch.buf_size),
    .sum      (ring_sum),
    .bad      (ring_bad)
  );

  // Residual shifts the count so the sequence survives timestamp wrap
  assign div_dividend = {1'b0, st_reg.ev.timestamp} + {1'b0, st_reg.rem_adj};

  atc_seq_div u_div (
    .sys_clk  (sys_clk),
    .rst_n    (rst_n),
    .start    (st_reg.div_go),
    .dividend (div_dividend),
    .divisor  (st_reg.ch.seq_interval),
    .done     (div_done),
    .quotient (div_q)
  );

  assign total_samples = {8'h00, st_reg.ch.bearers} * {8'h00, st_reg.ch.spp};
  assign payload_len   = payload_octets(st_reg.ev.rate, total_samples, st_reg.ev.sid_len);
  assign seq_uui       = merge_uui(st_reg.ch.fixed_uui[st_reg.ev.rate], div_q[4:0],
                                   st_reg.ch.seq_bits);

  always_comb begin
    logic [31:0] period;
    logic [32:0] rsum;
    period = 32'h00000000;
    rsum   = 33'h000000000;
    st_next = st_reg;
    st_next.pkt.valid = 1'b0;
    st_next.wb.valid  = 1'b0;
    st_next.bad_buf   = 1'b0;
    st_next.div_go    = 1'b0;
    unique case (st_reg.fsm)
      atc_pkg::ATC_S_IDLE: begin
        if (svc.valid) begin
          st_next.ch  = chan;
          st_next.ev  = svc;
          st_next.fsm = atc_pkg::ATC_S_EVAL;
        end else if (inj.valid) begin
          // Processor packets bypass the voice path and the init gate
          st_next.pkt.valid     = 1'b1;
          st_next.pkt.from_cpu  = 1'b1;
          st_next.pkt.vc_base   = chan.vc_base;
          st_next.pkt.cid       = inj.cid;
          st_next.pkt.uui       = inj.uui;
          st_next.pkt.li        = inj.len;
          st_next.pkt.start_ptr = chan.next_ptr;
          st_next.pkt.bearers   = 8'h00;
          st_next.pkt.samples   = 16'h0000;
          st_next.wb            = wb_from(chan);
          st_next.wb.pkt_cnt    = chan.pkt_cnt + 32'h00000001;
          st_next.wb.oct_cnt    = count_octets(chan.oct_cnt, inj.len);
        end
      end
      atc_pkg::ATC_S_EVAL: begin
        if (!st_reg.ch.chan_valid) begin
          st_next.fsm = atc_pkg::ATC_S_IDLE;
        end else if (ring_bad) begin
          // Reserved size code: drop the event rather than corrupt the ring
          st_next.bad_buf = 1'b1;
          st_next.fsm     = atc_pkg::ATC_S_IDLE;
        end else if (st_reg.ev.first_service_flag && !st_reg.ch.init) begin
          st_next.wb          = wb_from(st_reg.ch);
          st_next.wb.init     = 1'b1;
          st_next.wb.next_ptr = ring_sum;
          st_next.wb.t_msb    = st_reg.ev.timestamp[31];
          st_next.fsm         = atc_pkg::ATC_S_IDLE;
        end else if (!st_reg.ch.init) begin
          st_next.fsm = atc_pkg::ATC_S_IDLE;
        end else begin
          period  = {16'h0000, st_reg.ch.seq_interval} << seq_bits_eff(st_reg.ch.seq_bits);
          st_next.rem_adj = st_reg.ch.t_rem;
          st_next.wrapped = st_reg.ch.t_msb && !st_reg.ev.timestamp[31];
          if (st_next.wrapped) begin
            rsum = {1'b0, st_reg.ch.t_rem} + {1'b0, st_reg.ch.wrap_inc};
            if (rsum >= {1'b0, period}) begin
              rsum = rsum - {1'b0, period};
            end
            st_next.rem_adj = rsum[31:0];
          end
          st_next.div_go = 1'b1;
          st_next.fsm    = atc_pkg::ATC_S_SEQ;
        end
      end
      atc_pkg::ATC_S_SEQ: begin
        if (div_done) begin
          st_next.pkt.valid     = 1'b1;
          st_next.pkt.from_cpu  = 1'b0;
          st_next.pkt.vc_base   = st_reg.ch.vc_base;
          st_next.pkt.cid       = st_reg.ch.cid;
          st_next.pkt.uui       = seq_uui;
          st_next.pkt.li        = payload_len;
          st_next.pkt.start_ptr = st_reg.ch.next_ptr;
          st_next.pkt.bearers   = st_reg.ch.bearers;
          st_next.pkt.samples   = total_samples;
          st_next.wb            = wb_from(st_reg.ch);
          st_next.wb.next_ptr   = ring_sum;
          st_next.wb.t_rem      = st_reg.rem_adj;
          st_next.wb.t_msb      = st_reg.ev.timestamp[31];
          st_next.wb.pkt_cnt    = st_reg.ch.pkt_cnt + 32'h00000001;
          st_next.wb.oct_cnt    = count_octets(st_reg.ch.oct_cnt, payload_len);
          st_next.fsm           = atc_pkg::ATC_S_SEND;
        end
      end
      atc_pkg::ATC_S_SEND: begin
        // One idle beat lets the write-back land before the next fetch
        st_next.fsm = atc_pkg::ATC_S_IDLE;
      end
      default: begin
        st_next.fsm = atc_pkg::ATC_S_IDLE;
      end
    endcase
    st_next.busy = (st_next.fsm != atc_pkg::ATC_S_IDLE);
  end

  function automatic logic [2:0] seq_bits_eff(input logic [2:0] nbits);
    seq_bits_eff = (nbits > atc_pkg::SEQ_BITS_MAX) ? atc_pkg::SEQ_BITS_MAX : nbits;
  endfunction

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      st_reg     <= '0;
      st_reg.fsm <= atc_pkg::ATC_S_IDLE;
    end else begin
      st_reg <= st_next;
    end
  end

  assign busy         = st_reg.busy;
  assign bad_buf_size = st_reg.bad_buf;
  assign pkt_out      = st_reg.pkt;
  assign wb_out       = st_reg.wb;

endmodule

// File: rtl/atc_pkg.sv
package atc_pkg;

  localparam logic [2:0]  BUF_CODE_256    = 3'h0;
  localparam logic [2:0]  BUF_CODE_512    = 3'h1;
  localparam logic [9:0]  BUF_MASK_256    = 10'h0ff;
  localparam logic [9:0]  BUF_MASK_512    = 10'h1ff;
  localparam logic [31:0] OCTET_OVERHEAD  = 32'h00000004;
  localparam logic [2:0]  SEQ_BITS_MAX    = 3'h4;
  localparam logic [5:0]  DIV_STEPS       = 6'h21;
  localparam logic [4:0]  UUI_ONE         = 5'h01;
  localparam logic [2:0]  CODE_OF_64K     = 3'h0;
  localparam logic [2:0]  CODE_OF_40K     = 3'h1;
  localparam logic [2:0]  CODE_OF_32K     = 3'h2;
  localparam logic [2:0]  CODE_OF_24K     = 3'h3;
  localparam logic [2:0]  CODE_OF_16K     = 3'h4;
  localparam logic [2:0]  CODE_OF_SID     = 3'h5;

  typedef enum logic [2:0] {
    ATC_RATE_64 = CODE_OF_64K,
    ATC_RATE_40 = CODE_OF_40K,
    ATC_RATE_32 = CODE_OF_32K,
    ATC_RATE_24 = CODE_OF_24K,
    ATC_RATE_16 = CODE_OF_16K,
    ATC_RATE_SID = CODE_OF_SID
  } atc_rate_e;

  typedef enum logic [3:0] {
    ATC_S_IDLE = 4'h1,
    ATC_S_EVAL = 4'h2,
    ATC_S_SEQ  = 4'h4,
    ATC_S_SEND = 4'h8
  } atc_fsm_e;

  // Connection structure plus voice channel addition, as fetched from memory
  typedef struct packed {
    logic [19:0]     vc_base;
    logic [7:0]      cid;
    logic [5:0][4:0] fixed_uui;
    logic [2:0]      seq_bits;
    logic [15:0]     seq_interval;
    logic [31:0]     wrap_inc;
    logic [31:0]     t_rem;
    logic            t_msb;
    logic            chan_valid;
    logic            init;
    logic [9:0]      next_ptr;
    logic [2:0]      buf_size;
    logic [7:0]      bearers;
    logic [7:0]      spp;
    logic [31:0]     pkt_cnt;
    logic [31:0]     oct_cnt;
  } atc_chan_s;

  typedef struct packed {
    logic        valid;
    logic        first_service_flag;
    atc_rate_e   rate;
    logic [15:0] sid_len;
    logic [9:0]  wr_ptr;
    logic [31:0] timestamp;
  } atc_svc_s;

  typedef struct packed {
    logic        valid;
    logic [7:0]  cid;
    logic [4:0]  uui;
    logic [15:0] len;
  } atc_inj_s;

  typedef struct packed {
    logic        valid;
    logic        from_cpu;
    logic [19:0] vc_base;
    logic [7:0]  cid;
    logic [4:0]  uui;
    logic [15:0] li;
    logic [9:0]  start_ptr;
    logic [7:0]  bearers;
    logic [15:0] samples;
  } atc_pkt_s;

  typedef struct packed {
    logic        valid;
    logic        init;
    logic [9:0]  next_ptr;
    logic [31:0] t_rem;
    logic        t_msb;
    logic [31:0] pkt_cnt;
    logic [31:0] oct_cnt;
  } atc_wb_s;

endpackage

// File: rtl/atc_ring_ptr.sv
`timescale 1ns/1ps
module atc_ring_ptr (
  input  wire logic [9:0]  base,
  input  wire logic [15:0] add,
  input  wire logic [2:0]  buf_size,
  output logic      [9:0]  sum,
  output logic             bad
);
  logic [15:0] raw;

  // Buffer sizes are powers of two, so the wrap is a mask
  always_comb begin
    raw = {6'h00, base} + add;
    bad = 1'b0;
    unique case (buf_size)
      atc_pkg::BUF_CODE_256: sum = raw[9:0] & atc_pkg::BUF_MASK_256;
      atc_pkg::BUF_CODE_512: sum = raw[9:0] & atc_pkg::BUF_MASK_512;
      default: begin
        sum = base;
        bad = 1'b1;
      end
    endcase
  end
endmodule

// File: rtl/atc_seq_div.sv
`timescale 1ns/1ps
module atc_seq_div (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic        start,
  input  wire logic [32:0] dividend,
  input  wire logic [15:0] divisor,
  output logic             done,
  output logic      [32:0] quotient
);
  typedef struct packed {
    logic        busy;
    logic        done;
    logic [5:0]  cnt;
    logic [16:0] rem;
    logic [32:0] q;
  } atc_div_s;

  atc_div_s st_reg;
  atc_div_s st_next;
  logic [16:0] trial;

  // Restoring divide, one quotient bit a cycle; small area beats latency here
  always_comb begin
    st_next = st_reg;
    st_next.done = 1'b0;
    trial = {st_reg.rem[15:0], st_reg.q[32]};
    if (start) begin
      st_next.busy = 1'b1;
      st_next.cnt  = atc_pkg::DIV_STEPS;
      st_next.rem  = 17'h00000;
      st_next.q    = dividend;
    end else if (st_reg.busy) begin
      if (trial >= {1'b0, divisor}) begin
        st_next.rem = trial - {1'b0, divisor};
        st_next.q   = {st_reg.q[31:0], 1'b1};
      end else begin
        st_next.rem = trial;
        st_next.q   = {st_reg.q[31:0], 1'b0};
      end
      st_next.cnt = st_reg.cnt - 6'h01;
      if (st_reg.cnt == 6'h01) begin
        st_next.busy = 1'b0;
        st_next.done = 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign done     = st_reg.done;
  assign quotient = st_reg.q;
endmodule

// File: testbench/atc_tx_assembly_monitor.sv
`timescale 1ns/1ps
module atc_tx_assembly_monitor (
  input wire logic               sys_clk,
  input wire logic               rst_n,
  input wire atc_pkg::atc_chan_s chan,
  input wire atc_pkg::atc_svc_s  svc,
  input wire atc_pkg::atc_inj_s  inj,
  input wire logic               busy,
  input wire logic               bad_buf_size,
  input wire atc_pkg::atc_pkt_s  pkt_out,
  input wire atc_pkg::atc_wb_s   wb_out
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  logic take_svc;
  logic take_inj;
  assign take_svc = svc.valid && !busy;
  assign take_inj = inj.valid && !busy && !svc.valid;

  a_pair_pkt_wb: assert property (pkt_out.valid |-> wb_out.valid)
    else $error("packet without write-back");
  a_inj_own_cid: assert property (take_inj |=> pkt_out.valid && pkt_out.from_cpu
    && pkt_out.cid == $past(inj.cid)) else $error("injected packet cid wrong");
  a_voice_cid_vc: assert property (pkt_out.valid && !pkt_out.from_cpu |->
    pkt_out.cid == chan.cid && pkt_out.vc_base == chan.vc_base) else $error("voice cid wrong");
  a_pkt_count: assert property (pkt_out.valid |-> wb_out.pkt_cnt == chan.pkt_cnt + 32'h1)
    else $error("packet count wrong");
  a_octet_count: assert property (pkt_out.valid |->
    wb_out.oct_cnt == chan.oct_cnt + {16'h0, pkt_out.li} + 32'h4) else $error("octets wrong");
  a_invalid_quiet: assert property (take_svc && !chan.chan_valid |=>
    (!pkt_out.valid && !wb_out.valid)[*8]) else $error("invalid channel produced output");
  a_uninit_quiet: assert property (take_svc && !chan.init && !svc.first_service_flag |=>
    (!pkt_out.valid)[*8]) else $error("uninitialised channel sent");
  a_first_service: assert property (take_svc && chan.chan_valid && !chan.init
    && svc.first_service_flag && chan.buf_size < 3'h2 |-> ##2 wb_out.valid && wb_out.init
    && !pkt_out.valid) else $error("first service handling wrong");
  a_bad_size: assert property (take_svc && chan.chan_valid && svc.first_service_flag
    && chan.buf_size > 3'h1 |-> ##2 bad_buf_size) else $error("reserved size not flagged");
  a_voice_time: assert property (take_svc && chan.chan_valid && chan.init
    && chan.buf_size < 3'h2 |-> ##37 pkt_out.valid) else $error("voice packet late");

  c_inject: cover property (take_inj);
  c_voice: cover property (pkt_out.valid && !pkt_out.from_cpu);
  c_bad: cover property (bad_buf_size);
  c_first: cover property (wb_out.valid && wb_out.init && !pkt_out.valid);
endmodule

bind atc_tx_assembly atc_tx_assembly_monitor u_mon (.sys_clk(sys_clk), .rst_n(rst_n),
  .chan(chan), .svc(svc), .inj(inj), .busy(busy), .bad_buf_size(bad_buf_size),
  .pkt_out(pkt_out), .wb_out(wb_out));

// File: testbench/atc_cell_sink.sv
`timescale 1ns/1ps
module atc_cell_sink (
  input  wire logic              sys_clk,
  input  wire logic              rst_n,
  input  wire atc_pkg::atc_pkt_s pkt,
  output logic [15:0]            cell_cnt,
  output atc_pkg::atc_pkt_s      last_pkt
);
  // Cell path has no back-pressure toward the block, so every strobe is taken
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      cell_cnt <= 16'h0000;
      last_pkt <= '0;
    end else if (pkt.valid) begin
      cell_cnt <= cell_cnt + 16'h0001;
      last_pkt <= pkt;
    end
  end
endmodule

// File: testbench/atc_tx_assembly_bench.sv
`timescale 1ns/1ps
module atc_tx_assembly_bench;
  logic               sys_clk;
  logic               rst_n;
  atc_pkg::atc_chan_s chan;
  atc_pkg::atc_svc_s  svc;
  atc_pkg::atc_inj_s  inj;
  logic               busy;
  logic               bad_buf_size;
  atc_pkg::atc_pkt_s  pkt_out;
  atc_pkg::atc_wb_s   wb_out;
  atc_pkg::atc_pkt_s  sink_pkt;
  logic [15:0]        cell_cnt;
  logic [15:0]        c0;
  logic [15:0]        li_tab [6];
  int                 mismatches;
  int                 num_checks;
  int                 cycles;

  atc_tx_assembly uut (.sys_clk(sys_clk), .rst_n(rst_n), .chan(chan), .svc(svc), .inj(inj),
    .busy(busy), .bad_buf_size(bad_buf_size), .pkt_out(pkt_out), .wb_out(wb_out));
  atc_cell_sink u_sink (.sys_clk(sys_clk), .rst_n(rst_n), .pkt(pkt_out),
    .cell_cnt(cell_cnt), .last_pkt(sink_pkt));

  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  always @(posedge sys_clk) begin
    cycles = cycles + 1;
    if (cycles == 2000) begin
      mismatches = mismatches + 1;
      report_and_stop();
    end
  end

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks = num_checks + 1;
    if (got !== exp) begin
      mismatches = mismatches + 1;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic settle();
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 60) begin
      @(posedge sys_clk);
      n = n + 1;
    end
    @(posedge sys_clk);
  endtask

  // Bounded wait on a strobe; bad selects the size-error pulse
  task automatic wait_for(input logic bad);
    int n;
    n = 0;
    while ((bad ? bad_buf_size : wb_out.valid) !== 1'b1 && n < 50) begin
      @(posedge sys_clk);
      n = n + 1;
    end
  endtask

  task automatic send_svc(input logic fs, input logic [2:0] r, input logic [9:0] wp,
                          input logic [31:0] ts);
    svc <= atc_pkg::atc_svc_s'({1'b1, fs, r, 16'h001e, wp, ts});
    @(posedge sys_clk);
    svc.valid <= 1'b0;
  endtask

  task automatic run_voice(input logic [2:0] r, input logic [2:0] sb, input logic [31:0] ts,
                           input logic [4:0] q);
    logic [4:0] m;
    m = (5'h01 << sb) - 5'h01;
    c0 = cell_cnt;
    chan.seq_bits <= sb;
    send_svc(1'b0, r, 10'h000, ts);
    wait_for(1'b0);
    check("pkt strobe", 32'h00000001, {31'h0, pkt_out.valid});
    check("busy", 32'h00000001, {31'h0, busy});
    check("from cpu", 32'h00000000, {31'h0, pkt_out.from_cpu});
    check("cid", {24'h0, chan.cid}, {24'h0, pkt_out.cid});
    check("uui", {27'h0, (chan.fixed_uui[r] & ~m) | (q & m)}, {27'h0, pkt_out.uui});
    check("li", {16'h0, li_tab[r]}, {16'h0, pkt_out.li});
    check("bearers", 32'h00000002, {24'h0, pkt_out.bearers});
    check("samples", 32'h00000010, {16'h0, pkt_out.samples});
    check("start ptr", 32'h000001fc, {22'h0, pkt_out.start_ptr});
    check("next ptr", 32'h00000004, {22'h0, wb_out.next_ptr});
    check("pkt cnt", chan.pkt_cnt + 32'h1, wb_out.pkt_cnt);
    check("oct cnt", chan.oct_cnt + {16'h0, li_tab[r]} + 32'h4, wb_out.oct_cnt);
    settle();
    check("cells", {16'h0, c0 + 16'h1}, {16'h0, cell_cnt});
    check("sink vc", {12'h0, chan.vc_base}, {12'h0, sink_pkt.vc_base});
  endtask

  initial begin
    mismatches = 0;
    num_checks = 0;
    cycles = 0;
    rst_n = 1'b0;
    svc = '0;
    inj = '0;
    // Image of one structure slot; its aligned address is not a port
    chan = '0;
    li_tab = '{16'h0010, 16'h000a, 16'h0008, 16'h0006, 16'h0004, 16'h001e};
    chan.vc_base = 20'h0a5c0;
    chan.cid = 8'h21;
    chan.fixed_uui = {5'h19, 5'h06, 5'h11, 5'h1b, 5'h0e, 5'h15};
    chan.seq_interval = 16'h0028;
    chan.t_rem = 32'h0;
    chan.init = 1'b0;
    chan.chan_valid = 1'b1;
    chan.bearers = 8'h02;
    chan.spp = 8'h08;
    // Counter at its top value shows the free-running wrap
    chan.pkt_cnt = 32'hffffffff;
    chan.oct_cnt = 32'h00001000;
    repeat (12) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    inj <= atc_pkg::atc_inj_s'({1'b1, 8'h5a, 5'h0a, 16'h0014});
    @(posedge sys_clk);
    inj <= atc_pkg::atc_inj_s'({1'b1, 8'h77, 5'h0b, 16'h002c});
    @(posedge sys_clk);
    check("inj cid", 32'h0000005a, {24'h0, pkt_out.cid});
    check("inj uui", 32'h0000000a, {27'h0, pkt_out.uui});
    check("inj src", 32'h00000001, {31'h0, pkt_out.from_cpu});
    check("inj oct", 32'h00001018, wb_out.oct_cnt);
    inj.valid <= 1'b0;
    @(posedge sys_clk);
    check("inj2 cid", 32'h00000077, {24'h0, pkt_out.cid});
    check("inj2 cnt", 32'h00000000, wb_out.pkt_cnt);
    check("inj2 oct", 32'h00001030, wb_out.oct_cnt);
    // Second inject's cell lands one edge later; wait before sampling the count
    settle();
    check("inj cells", 32'h00000002, {16'h0, cell_cnt});
    $display("test inject done");
    c0 = cell_cnt;
    chan.chan_valid <= 1'b0;
    chan.init <= 1'b1;
    send_svc(1'b1, 3'h0, 10'h000, 32'h000002f8);
    repeat (45) @(posedge sys_clk);
    chan.chan_valid <= 1'b1;
    chan.init <= 1'b0;
    send_svc(1'b0, 3'h0, 10'h000, 32'h000002f8);
    repeat (45) @(posedge sys_clk);
    check("quiet cells", {16'h0, c0}, {16'h0, cell_cnt});
    $display("test quiet done");
    chan.buf_size <= 3'h2;
    send_svc(1'b1, 3'h0, 10'h000, 32'h000002f8);
    wait_for(1'b1);
    check("bad size", 32'h00000001, {31'h0, bad_buf_size});
    settle();
    chan.buf_size <= 3'h0;
    chan.next_ptr <= 10'h010;
    send_svc(1'b1, 3'h0, 10'h0f8, 32'h000002f8);
    wait_for(1'b0);
    check("init set", 32'h00000001, {31'h0, wb_out.init});
    check("first ptr", 32'h00000008, {22'h0, wb_out.next_ptr});
    check("no pkt", 32'h00000000, {31'h0, pkt_out.valid});
    settle();
    $display("test first service done");
    chan.init <= 1'b1;
    chan.buf_size <= 3'h1;
    chan.next_ptr <= 10'h1fc;
    for (int i = 0; i < 6; i++) begin
      run_voice(3'(i), (i == 5) ? 3'h0 : 3'(i), 32'h000002f8, 5'h13);
    end
    $display("test voice rates done");
    chan.t_msb <= 1'b1;
    chan.wrap_inc <= 32'h00000100;
    run_voice(3'h0, 3'h4, 32'h000002f8, 5'h19);
    check("t_rem", 32'h00000100, wb_out.t_rem);
    check("t_msb", 32'h00000000, {31'h0, wb_out.t_msb});
    $display("test wrap done");
    report_and_stop();
  end
endmodule
